// [eic_core.sv]
// encoder configuration: resolution and incremental frequency settings with power-on apply
`timescale 1ns/1ps
`default_nettype none
module eic_core
    import eic_pkg::*;
#(
    parameter int POS_W = 46
) (
    input  wire logic                  SYS_CLK_I,
    input  wire logic                  RESET_I,
    input  wire logic                  POWER_ON_I,
    input  wire logic                  STAGE_EN_I,
    input  wire eic_pkg::eic_req_t     REQ_I,
    output logic                       ACK_O,
    output logic                       ERR_O,
    output logic [15:0]                RDATA_O,
    output logic [31:0]                ST_INC_O,
    output logic [24:0]                MT_TURNS_O,
    output logic [31:0]                MAX_INC_RATE_O,
    input  wire logic [POS_W-1:0]      RAW_POS_I,
    output logic [POS_W-1:0]           POS_O,
    output logic [4:0]                 ACT_SGL_O,
    output logic [4:0]                 ACT_MUL_O
);
    import eic_pkg::*;


    // ****************************************
    // elaboration checks
    // ****************************************
    // the mask below and the package limits assume a 46-bit word; a narrower word
    // would drop turn bits, a wider one would carry bits that no encoder drives
    if (POS_W != EIC_POS_W) begin : g_bad_pos_w
        $error("eic_core: POS_W must equal EIC_POS_W");
    end

    // ****************************************
    // register select
    // ****************************************
    // one code per mapped register; anything else decodes to none and is refused
    typedef enum logic [1:0] {
        EIC_SEL_NONE = 2'b00,
        EIC_SEL_FREQ = 2'b01,
        EIC_SEL_SGL  = 2'b10,
        EIC_SEL_MUL  = 2'b11
    } eic_sel_t;

    // ****************************************
    // state and next values
    // ****************************************
    eic_cfg_t         stored_q;
    eic_cfg_t         stored_d;
    eic_cfg_t         active_q;
    eic_cfg_t         active_d;
    logic             ack_q;
    logic             ack_d;
    logic             err_q;
    logic             err_d;
    logic [15:0]      rdata_q;
    logic [15:0]      rdata_d;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] pos_d;
    logic [5:0]       width_sum;
    logic [POS_W-1:0] pos_keep;
    eic_sel_t         sel;
    logic             wr_ok;

    // ****************************************
    // helper functions
    // ****************************************
    // address decode, shared by the range check and both access paths
    function automatic eic_sel_t reg_sel(input logic [15:0] a);
        eic_sel_t s;
        case (a)
            EIC_OFS_MAXFREQ: s = EIC_SEL_FREQ;
            EIC_OFS_SGL:     s = EIC_SEL_SGL;
            EIC_OFS_MUL:     s = EIC_SEL_MUL;
            default:         s = EIC_SEL_NONE;
        endcase
        return s;
    endfunction : reg_sel

    // range check per register; an out-of-range value is refused, never clipped
    function automatic logic in_range(input eic_sel_t s, input logic [15:0] v);
        logic ok;
        case (s)
            EIC_SEL_FREQ: ok = (v >= EIC_MIN_MAXFREQ) && (v <= EIC_MAX_MAXFREQ);
            EIC_SEL_SGL:  ok = (v >= EIC_MIN_SGL) && (v <= EIC_MAX_SGL);
            EIC_SEL_MUL:  ok = (v <= EIC_MAX_MUL);
            default:      ok = 1'b0;
        endcase
        return ok;
    endfunction : in_range

    // one-hot power of two, for the turn increments and the turn count alike
    function automatic logic [31:0] pow2(input logic [4:0] n);
        return 32'h0000_0001 << n;
    endfunction : pow2

    // ****************************************
    // request decode
    // ****************************************
    // decode once so that the write and read paths agree on the target
    always_comb begin
        sel   = reg_sel(REQ_I.addr);
        wr_ok = !STAGE_EN_I && in_range(sel, REQ_I.wdata);
    end

    // ****************************************
    // stored settings
    // ****************************************
    // a refused write leaves every stored field untouched; the sum of the two
    // widths is the configurer's duty and is deliberately not checked here
    always_comb begin
        stored_d = stored_q;
        if (REQ_I.wr && wr_ok) begin
            case (sel)
                EIC_SEL_FREQ: stored_d.maxfreq = REQ_I.wdata;
                EIC_SEL_SGL:  stored_d.sgl     = REQ_I.wdata;
                EIC_SEL_MUL:  stored_d.mul     = REQ_I.wdata;
                default:      stored_d         = stored_q;
            endcase
        end
    end

    // ****************************************
    // active settings
    // ****************************************
    // evaluation only sees the active copy, so a write while running cannot
    // shift the position word under a moving axis
    always_comb begin
        active_d = active_q;
        if (POWER_ON_I) begin
            active_d = stored_q;
        end
    end

    // reset loads the factory defaults into both copies; a reset of the logic
    // stands in for a restore from the persistent store
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            stored_q <= '{EIC_RST_MAXFREQ, EIC_RST_SGL, EIC_RST_MUL};
            active_q <= '{EIC_RST_MAXFREQ, EIC_RST_SGL, EIC_RST_MUL};
        end else begin
            stored_q <= stored_d;
            active_q <= active_d;
        end
    end

    // ****************************************
    // access answer
    // ****************************************
    // ack pulses once per request, err marks any refusal, rdata holds the last read;
    // reads return the stored value, which may differ from the active one
    always_comb begin
        ack_d   = REQ_I.wr | REQ_I.rd;
        err_d   = 1'b0;
        rdata_d = rdata_q;
        if (REQ_I.wr) begin
            err_d = !wr_ok;
        end else if (REQ_I.rd) begin
            case (sel)
                EIC_SEL_FREQ: rdata_d = stored_q.maxfreq;
                EIC_SEL_SGL:  rdata_d = stored_q.sgl;
                EIC_SEL_MUL:  rdata_d = stored_q.mul;
                default: begin
                    rdata_d = 16'h0000;
                    err_d   = 1'b1;
                end
            endcase
        end
    end

    // answer registers
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q   <= ack_d;
            err_q   <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // position word
    // ****************************************
    // the widths are at most 25 and 24, so six bits hold their sum; turn bits sit
    // directly above the in-turn bits, everything higher is cleared
    always_comb begin
        width_sum = active_q.sgl[5:0] + active_q.mul[5:0];
        pos_keep  = ~({POS_W{1'b1}} << width_sum);
        pos_d     = RAW_POS_I & pos_keep;
    end

    // one cycle of latency on the position word
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pos_q <= '0;
        end else begin
            pos_q <= pos_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // register bus answer and position word
    assign ACK_O          = ack_q;
    assign ERR_O          = err_q;
    assign RDATA_O        = rdata_q;
    assign POS_O          = pos_q;
    // active widths as seen by evaluation
    assign ACT_SGL_O      = active_q.sgl[4:0];
    assign ACT_MUL_O      = active_q.mul[4:0];
    // derived figures from the active settings
    assign ST_INC_O       = pow2(active_q.sgl[4:0]);
    assign MT_TURNS_O     = 25'(pow2(active_q.mul[4:0]));
    assign MAX_INC_RATE_O = 32'(active_q.maxfreq) * 32'd1000 * 32'(EIC_INC_PER_CYC);
endmodule : eic_core
`default_nettype wire

// [eic_enc_model.sv]
// partner: serial position source, turn count above the in-turn bits
`timescale 1ns/1ps
`default_nettype none
module eic_enc_model #(parameter int POS_W = 46) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    output logic [POS_W-1:0] pos_o);
    logic [POS_W-1:0] pos_q, pos_d;
    // odd large step so the high turn bits toggle within a short run
    always_comb pos_d = pos_q + POS_W'(46'h0abcdef12345);
    always_ff @(posedge clk_i) pos_q <= reset_i ? '0 : pos_d;
    assign pos_o = pos_q;
endmodule : eic_enc_model
`default_nettype wire

// [eic_pkg.sv]
// package: register map, reset values and record types of the encoder configuration block
package eic_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [15:0] EIC_OFS_MAXFREQ = 16'h520c;
    localparam logic [15:0] EIC_OFS_SGL     = 16'h5210;
    localparam logic [15:0] EIC_OFS_MUL     = 16'h5212;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [15:0] EIC_RST_MAXFREQ = 16'h03e8;
    localparam logic [15:0] EIC_RST_SGL     = 16'h000d;
    localparam logic [15:0] EIC_RST_MUL     = 16'h0000;
    localparam logic [15:0] EIC_MIN_MAXFREQ = 16'h0001;
    localparam logic [15:0] EIC_MAX_MAXFREQ = 16'h03e8;
    localparam logic [15:0] EIC_MIN_SGL     = 16'h0008;
    localparam logic [15:0] EIC_MAX_SGL     = 16'h0019;
    localparam logic [15:0] EIC_MAX_MUL     = 16'h0018;
    localparam logic [15:0] EIC_MAX_SUM     = 16'h002e;
    localparam logic [2:0]  EIC_INC_PER_CYC = 3'h4;
    localparam int          EIC_POS_W       = 46;

    // ****************************************
    // record types
    // ****************************************
    typedef struct packed {
        logic [15:0] maxfreq;
        logic [15:0] sgl;
        logic [15:0] mul;
    } eic_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } eic_req_t;
endpackage : eic_pkg

// [eic_props.sv]
// checker: port timing and value relations of the encoder configuration block
`timescale 1ns/1ps
`default_nettype none
module eic_props import eic_pkg::*; #(parameter int POS_W = 46) (
    input wire logic SYS_CLK_I, RESET_I, POWER_ON_I, STAGE_EN_I, ACK_O, ERR_O,
    input wire eic_pkg::eic_req_t REQ_I,
    input wire logic [31:0] ST_INC_O, MAX_INC_RATE_O,
    input wire logic [24:0] MT_TURNS_O,
    input wire logic [POS_W-1:0] RAW_POS_I, POS_O,
    input wire logic [4:0] ACT_SGL_O, ACT_MUL_O);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);
    a_req_acked: assert property ((REQ_I.wr || REQ_I.rd) |=> ACK_O)
        else $error("request not answered");
    a_stage_refuse: assert property (REQ_I.wr && STAGE_EN_I |=> ERR_O)
        else $error("write taken with stage on");
    a_sgl_range: assert property (ACT_SGL_O inside {[8:25]}) else $error("sgl width");
    a_mul_range: assert property (ACT_MUL_O <= 5'd24) else $error("mul width");
    a_st_power: assert property (ST_INC_O == (32'h1 << ACT_SGL_O))
        else $error("turn increments");
    a_mt_power: assert property (MT_TURNS_O == (25'h1 << ACT_MUL_O))
        else $error("turn count");
    a_rate_scale: assert property (MAX_INC_RATE_O % 32'd4000 == 0
        && MAX_INC_RATE_O inside {[4000:4000000]}) else $error("rate scale");
    // active set may move only right after a power-on event
    a_active_hold: assert property (!POWER_ON_I |=> $stable({ACT_SGL_O, ACT_MUL_O}))
        else $error("active set moved");
    a_pos_mask: assert property (!$past(RESET_I) && $stable({ACT_SGL_O, ACT_MUL_O})
        |-> POS_O == ($past(RAW_POS_I) & ~({POS_W{1'b1}} << (6'(ACT_SGL_O) + 6'(ACT_MUL_O)))))
        else $error("position mask");
    c_refused: cover property (ERR_O);
    c_power: cover property (POWER_ON_I);
    c_stage_wr: cover property (REQ_I.wr && STAGE_EN_I);
endmodule : eic_props
`default_nettype wire

// [testbench.sv]
// testbench: register accesses, refusals and power-on apply of the encoder settings
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import eic_pkg::*;
    localparam int POS_W = 46;
    logic clk = 1'b0, rst = 1'b1, pon = 1'b0, stg = 1'b0, ack, err;
    eic_req_t req = '0;
    logic [15:0] rd;
    logic [31:0] st, rate;
    logic [24:0] mt;
    logic [POS_W-1:0] raw, pos;
    logic [4:0] asg, amu;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    eic_enc_model #(.POS_W(POS_W)) i_enc (.clk_i(clk), .reset_i(rst), .pos_o(raw));
    eic_core #(.POS_W(POS_W)) i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .POWER_ON_I(pon),
        .STAGE_EN_I(stg), .REQ_I(req), .ACK_O(ack), .ERR_O(err), .RDATA_O(rd), .ST_INC_O(st),
        .MT_TURNS_O(mt), .MAX_INC_RATE_O(rate), .RAW_POS_I(raw), .POS_O(pos),
        .ACT_SGL_O(asg), .ACT_MUL_O(amu));
    initial forever #2.5 clk = ~clk;
    task automatic check(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // one-cycle request, answer looked at in the cycle it stands
    task automatic xfer(input logic w, input logic [15:0] a, d, input logic e);
        @(posedge clk) req <= '{w, !w, a, d};
        @(posedge clk) req <= '0;
        #1 check({31'h0, ack}, 32'h1);
        check({31'h0, err}, {31'h0, e});
        if (!w) check({16'h0, rd}, {16'h0, d});
    endtask : xfer
    task automatic power_on;
        @(posedge clk) pon <= 1'b1;
        @(posedge clk) pon <= 1'b0;
        #1;
    endtask : power_on
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // hang guard, run needs some 53 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        xfer(0, EIC_OFS_MAXFREQ, 16'h03e8, 0);
        xfer(0, EIC_OFS_SGL, 16'h000d, 0);
        xfer(0, EIC_OFS_MUL, 16'h0000, 0);
        check(rate, 32'd4000000);
        xfer(1, EIC_OFS_SGL, 16'h0007, 1);
        xfer(1, EIC_OFS_SGL, 16'h001a, 1);
        xfer(1, EIC_OFS_SGL, 16'h0019, 0);
        xfer(1, EIC_OFS_MUL, 16'h0019, 1);
        xfer(1, EIC_OFS_MUL, 16'h0015, 0);
        xfer(1, EIC_OFS_MAXFREQ, 16'h0000, 1);
        xfer(1, EIC_OFS_MAXFREQ, 16'h03e9, 1);
        xfer(1, EIC_OFS_MAXFREQ, 16'h0001, 0);
        check(st, 32'd8192);
        @(posedge clk) stg <= 1'b1;
        xfer(1, EIC_OFS_SGL, 16'h0010, 1);
        @(posedge clk) stg <= 1'b0;
        xfer(0, EIC_OFS_SGL, 16'h0019, 0);
        power_on();
        check({27'h0, asg}, 32'd25);
        check(st, 32'h0200_0000);
        check({7'h0, mt}, 32'h0020_0000);
        check(rate, 32'd4000);
        xfer(1, EIC_OFS_MUL, 16'h0000, 0);
        power_on();
        check({7'h0, mt}, 32'h1);
        @(posedge clk) #1;
        check({27'h0, amu}, 32'h0);
        check({11'h0, pos[45:25]}, 32'h0);
        xfer(0, 16'h5214, 16'h0000, 1);
        results();
    end
endmodule : testbench
bind eic_core eic_props #(.POS_W(POS_W)) i_props (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
    .POWER_ON_I(POWER_ON_I), .STAGE_EN_I(STAGE_EN_I), .ACK_O(ACK_O), .ERR_O(ERR_O),
    .REQ_I(REQ_I), .ST_INC_O(ST_INC_O), .MAX_INC_RATE_O(MAX_INC_RATE_O), .POS_O(POS_O),
    .MT_TURNS_O(MT_TURNS_O), .RAW_POS_I(RAW_POS_I), .ACT_SGL_O(ACT_SGL_O), .ACT_MUL_O(ACT_MUL_O));
`default_nettype wire
